// *** verilog/spi_port_ctl.v ***
// Implementation choice: the APB slave port.
`timescale 1ns/10ps
`include "spi_ctl_regs.vh"
module spi_port_ctl (
    // Clock and reset
    input wire CLK,
    input wire RST_N,
    // APB slave
    input wire PSEL,
    input wire PENABLE,
    input wire PWRITE,
    input wire [11:0] PADDR,
    input wire [31:0] PWDATA,
    output reg [31:0] PRDATA,
    output wire PREADY,
    output wire PSLVERR,
    // Character data
    input wire [7:0] TX_CHAR,
    output reg TX_TAKE,
    output reg [7:0] RX_CHAR,
    output reg RX_VALID,
    output wire BUSY,
    // Serial clock pin
    input wire SCK_I,
    output wire SCK_O,
    output wire SCK_OE,
    // Select pin, active low on the wire
    input wire SS_N_I,
    output wire SS_N_O,
    output wire SS_N_OE,
    // Data pins
    input wire MOSI_I,
    output wire MOSI_O,
    output wire MOSI_OE,
    input wire MISO_I,
    output wire MISO_O,
    output wire MISO_OE
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN = 1'b1;
    localparam integer HALF_INT = `SCK_HALF_CYC - 1;
    localparam [7:0] HALF_M1 = HALF_INT[7:0];

    reg ctl_en;
    reg ctl_mst;
    reg three_wire;
    reg [1:0] lane;
    reg [15:0] tx_num;
    reg [15:0] rx_num;
    reg state;
    reg mst_run;
    reg fd_run;
    reg last;
    reg [15:0] tx_left;
    reg [15:0] rx_left;
    reg [2:0] bit_cnt;
    reg [7:0] shreg;
    // Outgoing bit loads at transfer start, then changes only on falling SCK so the far side never sees it move at its sample
    reg out_bit;
    reg sck_o;
    reg [7:0] div;
    reg sck_d;
    reg ss_d;
    wire [3:0] synced;
    wire sck_s;
    wire ss_s;
    wire mosi_s;
    wire miso_s;
    wire wr;
    wire rd_setup;
    wire full_duplex;
    wire run;
    wire phase_tx;
    wire div_hit;
    wire start_mst;
    wire start_tgt;
    wire sample;
    wire din;
    wire [7:0] rxd;
    wire [15:0] tx_next;
    wire [15:0] rx_next;
    reg [31:0] next_prdata;

    in_sync #(.W(4)) u_sync (
        .CLK(CLK),
        .RST_N(RST_N),
        .D({MISO_I, MOSI_I, SS_N_I, SCK_I}),
        .Q(synced)
    );
    assign sck_s = synced[0];
    assign ss_s = synced[1];
    assign mosi_s = synced[2];
    assign miso_s = synced[3];

    // Zero-wait slave: read data registered in the setup cycle
    assign wr = PSEL & PENABLE & PWRITE;
    assign rd_setup = PSEL & ~PENABLE & ~PWRITE;
    assign PREADY = PSEL & PENABLE;
    assign PSLVERR = PSEL & PENABLE & (PADDR != `OFS_PORT_PRIMARY_CONTROL) &
        (PADDR != `OFS_TRANSFER_LENGTH_CONFIG) & (PADDR != `OFS_LANE_CONFIG) &
        (PADDR != `OFS_PORT_STATUS);

    // Wide lanes make the three-wire bit irrelevant
    assign full_duplex = (lane == 2'b00) & ~three_wire;
    assign run = (state == ST_RUN);
    assign phase_tx = fd_run | (tx_left != 16'h0000);
    assign div_hit = (div == HALF_M1);
    assign start_mst = wr & (PADDR == `OFS_PORT_PRIMARY_CONTROL) & PWDATA[`BIT_START] &
        PWDATA[`BIT_EN] & PWDATA[`BIT_MST] & ~run;
    assign start_tgt = ctl_en & ~ctl_mst & ~run & ss_d & ~ss_s;
    // Controller samples on its own rising SCK, target on the synced rising edge
    assign sample = run & (mst_run ? (div_hit & ~sck_o & ~last) : (sck_s & ~sck_d));
    assign din = (mst_run & fd_run) ? miso_s : mosi_s;
    assign rxd = {shreg[6:0], din};
    assign tx_next = (bit_cnt == 3'h7 && phase_tx) ? tx_left - 16'h0001 : tx_left;
    assign rx_next = (bit_cnt == 3'h7 && (fd_run || !phase_tx)) ? rx_left - 16'h0001 : rx_left;

    always @* begin
        next_prdata = 32'h0000_0000;
        if (PADDR == `OFS_PORT_PRIMARY_CONTROL) begin
            next_prdata[`BIT_EN] = ctl_en;
            next_prdata[`BIT_MST] = ctl_mst;
            next_prdata[`BIT_START] = run & mst_run;
        end else if (PADDR == `OFS_TRANSFER_LENGTH_CONFIG) begin
            next_prdata = {rx_num, tx_num};
        end else if (PADDR == `OFS_LANE_CONFIG) begin
            next_prdata[`BIT_THREE_WIRE] = three_wire;
            next_prdata[`LANE_HI:`LANE_LO] = lane;
        end else if (PADDR == `OFS_PORT_STATUS) begin
            next_prdata = {rx_left[14:0], tx_left[14:0], 1'b0, run};
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            PRDATA <= 32'h0000_0000;
        end else if (rd_setup) begin
            PRDATA <= next_prdata;
        end
    end

    // Configuration; enable clear touches nothing else
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ctl_en <= 1'b0;
            ctl_mst <= 1'b0;
            tx_num <= 16'h0000;
            rx_num <= 16'h0000;
            three_wire <= 1'b0;
            lane <= 2'b00;
        end else if (wr) begin
            if (PADDR == `OFS_PORT_PRIMARY_CONTROL) begin
                ctl_en <= PWDATA[`BIT_EN];
                ctl_mst <= PWDATA[`BIT_MST];
            end else if (PADDR == `OFS_TRANSFER_LENGTH_CONFIG) begin
                rx_num <= PWDATA[`RX_NUM_HI:`RX_NUM_LO];
                tx_num <= PWDATA[`TX_NUM_HI:`TX_NUM_LO];
            end else if (PADDR == `OFS_LANE_CONFIG) begin
                three_wire <= PWDATA[`BIT_THREE_WIRE];
                lane <= PWDATA[`LANE_HI:`LANE_LO];
            end
        end
    end

    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sck_d <= 1'b0;
            // Select idles high; the synchronizer resets to 0, so a falling edge shows just after reset while enable is still 0
            ss_d <= 1'b1;
        end else begin
            sck_d <= sck_s;
            ss_d <= ss_s;
        end
    end

    // Transfer engine
    always @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state <= ST_IDLE;
            mst_run <= 1'b0;
            fd_run <= 1'b0;
            last <= 1'b0;
            tx_left <= 16'h0000;
            rx_left <= 16'h0000;
            bit_cnt <= 3'h0;
            shreg <= 8'h00;
            out_bit <= 1'b0;
            sck_o <= 1'b0;
            div <= 8'h00;
            TX_TAKE <= 1'b0;
            RX_VALID <= 1'b0;
            RX_CHAR <= 8'h00;
        end else begin
            TX_TAKE <= 1'b0;
            RX_VALID <= 1'b0;
            // A start word carries its own enable, so it may start from disabled
            if (!ctl_en && !start_mst) begin
                state <= ST_IDLE;
                sck_o <= 1'b0;
                div <= 8'h00;
                last <= 1'b0;
            end else if (state == ST_IDLE) begin
                div <= 8'h00;
                sck_o <= 1'b0;
                last <= 1'b0;
                bit_cnt <= 3'h0;
                if ((start_mst || start_tgt) &&
                    (tx_num != 16'h0000 || (!full_duplex && rx_num != 16'h0000))) begin
                    state <= ST_RUN;
                    mst_run <= start_mst;
                    fd_run <= full_duplex;
                    tx_left <= tx_num;
                    rx_left <= full_duplex ? tx_num : rx_num;
                    shreg <= TX_CHAR;
                    out_bit <= TX_CHAR[7];
                    // Receive-only transfers take nothing from the transmit side
                    TX_TAKE <= (tx_num != 16'h0000);
                end
            end else begin
                if (mst_run ? (div_hit & sck_o) : (sck_d & ~sck_s)) begin
                    out_bit <= shreg[7];
                end
                if (mst_run) begin
                    div <= div_hit ? 8'h00 : div + 8'h01;
                    if (div_hit) begin
                        sck_o <= ~sck_o & ~last;
                        if (sck_o && last) begin
                            state <= ST_IDLE;
                        end
                    end
                end else if (ss_s) begin
                    state <= ST_IDLE;
                end
                if (sample) begin
                    shreg <= rxd;
                    bit_cnt <= bit_cnt + 3'h1;
                    if (bit_cnt == 3'h7) begin
                        tx_left <= tx_next;
                        rx_left <= rx_next;
                        if (fd_run || !phase_tx) begin
                            RX_CHAR <= rxd;
                            RX_VALID <= 1'b1;
                        end
                        if (tx_next == 16'h0000 && rx_next == 16'h0000) begin
                            last <= 1'b1;
                            if (!mst_run) begin
                                state <= ST_IDLE;
                            end
                        end else begin
                            shreg <= TX_CHAR;
                            TX_TAKE <= fd_run | (tx_next != 16'h0000);
                        end
                    end
                end
            end
        end
    end

    assign BUSY = run;
    assign SCK_O = sck_o;
    assign SCK_OE = ctl_en & ctl_mst;
    assign SS_N_O = ~(run & mst_run);
    assign SS_N_OE = ctl_en & ctl_mst;
    // Drive holds through the final edge, except in half duplex or target role, where it drops once the last transmitted bit is sampled on rising SCK
    assign MOSI_O = out_bit;
    assign MOSI_OE = run & phase_tx & (mst_run | ~fd_run);
    assign MISO_O = out_bit;
    assign MISO_OE = run & ~mst_run & fd_run;
endmodule // spi_port_ctl

// *** verilog/spi_ctl_regs.vh ***
// What this block does
// - Role bit 0 runs the port as target, 1 as controller driving the link.
// - Port stays inactive while enable bit 0 reads 0; runs when it is 1.
// - Clearing enable keeps all configuration values; re-enabling resumes with them.
// - Receive character count comes from length register bits 31:16.
// - Transmit character count comes from length register bits 15:0.
// - Four-wire full duplex ignores receive count; transmit count serves both directions.
// - Full duplex when three-wire bit and lane width are 0; wide lanes ignore three-wire.
// - In controller role writing 1 to start begins a transaction.
`ifndef SPI_CTL_REGS_VH
`define SPI_CTL_REGS_VH

// Register byte offsets
`define OFS_PORT_PRIMARY_CONTROL 12'h000
`define OFS_TRANSFER_LENGTH_CONFIG 12'h008
`define OFS_LANE_CONFIG 12'h00C
`define OFS_PORT_STATUS 12'h010

// Field positions
`define BIT_EN 0
`define BIT_MST 1
`define BIT_START 5
`define RX_NUM_HI 31
`define RX_NUM_LO 16
`define TX_NUM_HI 15
`define TX_NUM_LO 0
`define BIT_THREE_WIRE 15
`define LANE_HI 13
`define LANE_LO 12
`define BIT_BUSY 0

// Reset values
`define RST_PRIMARY 32'h0000_0000
`define RST_LENGTH 32'h0000_0000
`define RST_LANE 32'h0000_0000

// Timing: least SCK half period in ns, clock period in ns
`define CLK_NS 100
`define SCK_HALF_NS 400
`define SCK_HALF_CYC ((`SCK_HALF_NS + `CLK_NS - 1) / `CLK_NS)

`endif

// *** verilog/in_sync.v ***
`timescale 1ns/10ps
module in_sync #(
    parameter W = 4
) (
    // Clock and reset
    input wire CLK,
    input wire RST_N,
    // Data
    input wire [W-1:0] D,
    output wire [W-1:0] Q
);
    reg [W-1:0] stage1;
    reg [W-1:0] stage2;
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            always @(posedge CLK or negedge RST_N) begin
                if (!RST_N) begin
                    stage1[i] <= 1'b0;
                    stage2[i] <= 1'b0;
                end else begin
                    stage1[i] <= D[i];
                    stage2[i] <= stage1[i];
                end
            end
        end
    endgenerate
    assign Q = stage2;
endmodule // in_sync

// *** verification/spi_port_ctl_sva.sv ***
`timescale 1ns/10ps
module spi_port_ctl_sva (
    // Bus
    input logic CLK,
    input logic RST_N,
    input logic PSEL,
    input logic PENABLE,
    input logic PWRITE,
    input logic [11:0] PADDR,
    input logic [31:0] PWDATA,
    input logic PREADY,
    input logic PSLVERR,
    // Port
    input logic TX_TAKE,
    input logic BUSY,
    input logic SCK_OE,
    input logic SS_N_O
);
    logic en, mst;
    logic [31:0] len;
    wire wr = PSEL && PENABLE && PWRITE;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RST_N);
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            {en, mst, len} <= 34'h0;
        end else if (wr && PADDR == 12'h000) begin
            {mst, en} <= PWDATA[1:0];
        end else if (wr && PADDR == 12'h008) begin
            len <= PWDATA;
        end
    end
    sequence ctl_wr_s;
        wr && PADDR == 12'h000;
    endsequence
    sequence start_s;
        ctl_wr_s ##0 (PWDATA[5] && PWDATA[1:0] == 2'h3 && !BUSY && len[15:0] != 16'h0);
    endsequence
    ready_a: assert property (PREADY == (PSEL && PENABLE)) else $error("PREADY wrong");
    bad_addr_a: assert property (PSEL && PENABLE |->
        PSLVERR == !(PADDR inside {12'h000, 12'h008, 12'h00C, 12'h010})) else $error("PSLVERR");
    start_busy_a: assert property (start_s |=> BUSY && !SS_N_O)
        else $error("start not taken");
    first_take_a: assert property (start_s |-> ##[1:2] TX_TAKE)
        else $error("no first character");
    sck_drive_a: assert property (SCK_OE == (en && mst))
        else $error("clock drive wrong");
    stop_a: assert property (ctl_wr_s ##0 !PWDATA[0] |-> ##[1:4] !BUSY)
        else $error("disable ignored");
    select_idle_a: assert property (!BUSY [*2] |-> SS_N_O)
        else $error("select while idle");
    zero_len_a: assert property (ctl_wr_s ##0 (!BUSY && len == 32'h0) |=> !BUSY)
        else $error("empty start ran");
endmodule // spi_port_ctl_sva

// *** verification/far_target.sv ***
`timescale 1ns/10ps
module far_target (
    // Link
    input logic sck,
    input logic ss_n,
    input logic sdi,
    output logic sdo,
    // Last character taken
    output logic [7:0] got
);
    logic [7:0] sh_out = 8'hC3, sh_in = 8'h00;
    int nbits = 0;
    initial {sdo, got} = 9'h0;
    always @(negedge ss_n) begin
        nbits = 0;
        sh_out = 8'hC3;
        sdo = sh_out[7];
    end
    // Mode 0: sample on rise, next bit out on fall
    always @(posedge sck) begin
        if (!ss_n) begin
            sh_in = {sh_in[6:0], sdi};
            nbits++;
            got = (nbits % 8 == 0) ? sh_in : got;
            sh_out = (nbits % 8 == 0) ? 8'hC3 + 8'(nbits / 8) : sh_out << 1;
        end
    end
    always @(negedge sck) begin
        if (!ss_n) sdo = sh_out[7];
    end
    // No pull on the line: inverse of the last bit once released
    always @(posedge ss_n) sdo = ~sdo;
endmodule // far_target

// *** verification/spi_enable_role_and_char_count_tb.sv ***
`timescale 1ns/10ps
module spi_enable_role_and_char_count_tb;
    logic clk = 1'h0, rst_n = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0;
    logic err, pready, pslverr, tx_take, rx_valid, busy, sck_o, sck_oe, ss_n_o, ss_n_oe;
    logic mosi_o, mosi_oe, miso_o, miso_oe, sdo;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdata, len;
    logic [7:0] tx_char = 8'h00, rx_char, last, far_got;
    logic [31:0] lanes [5] = '{32'h0, 32'h8000, 32'h1000, 32'h2000, 32'h9000};
    int num_errors = 0, comparisons = 0, ntake = 0, nrx = 0, seed;
    wire sck_w = sck_oe ? sck_o : 1'h0;
    wire ss_w = ss_n_oe ? ss_n_o : 1'h1;
    wire mosi_w = mosi_oe ? mosi_o : sdo;
    wire miso_w = miso_oe ? miso_o : sdo;
    always #50 clk = ~clk;
    spi_port_ctl u_dut (.CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .TX_CHAR(tx_char), .TX_TAKE(tx_take), .RX_CHAR(rx_char), .RX_VALID(rx_valid), .BUSY(busy),
        .SCK_I(sck_w), .SCK_O(sck_o), .SCK_OE(sck_oe), .SS_N_I(ss_w), .SS_N_O(ss_n_o),
        .SS_N_OE(ss_n_oe), .MOSI_I(mosi_w), .MOSI_O(mosi_o), .MOSI_OE(mosi_oe), .MISO_I(miso_w),
        .MISO_O(miso_o), .MISO_OE(miso_oe));
    far_target u_far (.sck(sck_w), .ss_n(ss_w), .sdi(mosi_w), .sdo(sdo), .got(far_got));
    function logic [31:0] exp_rx(input logic [31:0] lane, input logic [31:0] l);
        return (lane[15] || lane[13:12] != 2'h0) ? l[31:16] : l[15:0];
    endfunction
    task chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("Error at %0t: got %h, expected %h", $time, got, exp);
        end
    endtask
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'h1;
        @(posedge clk);
        while (pready !== 1'h1) @(posedge clk);
        rdata = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge clk);
    endtask
    task run(input logic [31:0] ctl);
        ntake = 0;
        nrx = 0;
        apb(1'h1, 12'h000, ctl);
        while (busy !== 1'h0) @(posedge clk);
        repeat (3) @(posedge clk);
    endtask
    task end_of_test;
        $display("Errors %0d, comparisons %0d", num_errors, comparisons);
        if (num_errors == 0 && comparisons > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    always @(posedge clk) begin
        if (rx_valid === 1'h1) begin
            nrx++;
            last = rx_char;
        end
        if (tx_take === 1'h1) ntake++;
    end
    initial begin
        repeat (20000) @(posedge clk);
        num_errors++;
        end_of_test();
    end
    initial begin
        seed = $urandom(32'hF46B);
        repeat (20) @(posedge clk);
        rst_n <= 1'h1;
        @(posedge clk);
        apb(1'h0, 12'h000, 32'h0);
        chk(rdata, 32'h0);
        apb(1'h0, 12'h004, 32'h0);
        chk({31'h0, err}, 32'h1);
        run(32'h23);
        chk(ntake, 32'h0);
        tx_char <= 8'($urandom);
        foreach (lanes[i]) begin
            len = {16'($urandom_range(3, 1)), 16'($urandom_range(3, 1))};
            apb(1'h1, 12'h00C, lanes[i]);
            apb(1'h1, 12'h008, len);
            apb(1'h0, 12'h008, 32'h0);
            chk(rdata, len);
            run(32'h23);
            chk(nrx, exp_rx(lanes[i], len));
            chk(ntake, len[15:0]);
            if (i == 0) chk(last, 8'hC2 + len[7:0]);
            if (i == 0) chk(far_got, tx_char);
        end
        apb(1'h1, 12'h00C, 32'h0);
        apb(1'h1, 12'h000, 32'h23);
        repeat (30) @(posedge clk);
        run(32'h2);
        apb(1'h0, 12'h008, 32'h0);
        chk(rdata, len);
        run(32'h23);
        chk(ntake, len[15:0]);
        run(32'h22);
        chk(nrx, 32'h0);
        end_of_test();
    end
endmodule // spi_enable_role_and_char_count_tb
bind spi_port_ctl spi_port_ctl_sva u_sva (.*);
